// file: rtl/rsc_map.vh
// Register map, field positions, reset values and timing for reset control
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// Register addresses (8-bit data bus)
`define RSC_ADDR_LVCTL        16'hff50
`define RSC_ADDR_LVLVL        16'hff51
`define RSC_ADDR_CAUSE        16'hff54

// Cause register fields
`define RSC_CAUSE_WDT_BIT     4
`define RSC_CAUSE_UV_BIT      0
`define RSC_CAUSE_RST         8'h00

// Undervoltage control register fields
`define RSC_LVCTL_EN_BIT      7
`define RSC_LVCTL_MODE_BIT    1
`define RSC_LVCTL_FLAG_BIT    0
`define RSC_LVCTL_RST         8'h00
`define RSC_LVLVL_MASK        8'h0f
`define RSC_LVLVL_RST         8'h00

// Reset vector location
`define RSC_VEC_LO_ADDR       16'h0000
`define RSC_VEC_HI_ADDR       16'h0001

// Hardware values after reset
`define RSC_RV_PSW            8'h02
`define RSC_RV_PORT_LATCH     8'h00
`define RSC_RV_PORT_DIR       8'hff
`define RSC_RV_PULLUP         8'h00
`define RSC_RV_IRQ_FLAG       8'h00
`define RSC_RV_IRQ_MASK       8'hff
`define RSC_RV_EDGE_MODE      8'h00
`define RSC_RV_TM_COUNT       16'h0000
`define RSC_RV_TM_CC          16'h0000
`define RSC_RV_TM_CTRL        8'h00
`define RSC_RV_FLASH          8'h00

// Timing, clock period and stop times in ns
`define RSC_CLK_NS            25
`define RSC_STOP_INT_MIN_NS   277000
`define RSC_STOP_INT_TYP_NS   544000
`define RSC_STOP_INT_MAX_NS   1075000
`define RSC_STOP_XTAL_MIN_NS  276000
`define RSC_STOP_XTAL_TYP_NS  544000
`define RSC_STOP_XTAL_MAX_NS  1074000
`define RSC_EXT_PULSE_NS      2000

// Derived cycle counts
`define RSC_STOP_INT_MIN_CYC  ((`RSC_STOP_INT_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_STOP_INT_TYP_CYC  (`RSC_STOP_INT_TYP_NS / `RSC_CLK_NS)
`define RSC_STOP_INT_MAX_CYC  (`RSC_STOP_INT_MAX_NS / `RSC_CLK_NS)
`define RSC_STOP_XTAL_MIN_CYC ((`RSC_STOP_XTAL_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_STOP_XTAL_TYP_CYC (`RSC_STOP_XTAL_TYP_NS / `RSC_CLK_NS)
`define RSC_STOP_XTAL_MAX_CYC (`RSC_STOP_XTAL_MAX_NS / `RSC_CLK_NS)
`define RSC_EXT_PULSE_CYC     ((`RSC_EXT_PULSE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_OSTAB_CYC         1024

`endif

// file: rtl/rsc_rst_sync.v
// Reset synchroniser: asserts at once, releases after two clock edges
`timescale 1ns/100ps
module rsc_rst_sync (
  mclk,
  arst_n,
  rst_sync_n
);
  input  wire mclk;
  input  wire arst_n;
  output wire rst_sync_n;

  reg         s1_r;
  reg         s2_r;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= 1'b1;
      s2_r <= s1_r;
    end
  end

  assign rst_sync_n = s2_r;
endmodule

// file: rtl/rsc_reset_ctrl.v
// Reset source merge, cause capture, CPU hold and reset vector fetch
// Notes on behaviour
// R1: Cause register: watchdog bit 4, undervoltage bit 0
// R2: Cause register read-only, 8-bit read access
// R3: Pin, power-on or read clears cause register
// R4: Watchdog reset sets watchdog flag; undervoltage holds
// R5: Undervoltage reset sets its flag; watchdog holds
// R6: Undervoltage registers survive only undervoltage reset
// R7: Watchdog reset also resets the watchdog
// R8: Internal clock: hold CPU during configuration
// R9: Crystal: hold CPU, then stabilisation wait
// R10: Load program counter from vector 0000/0001
// R11: During reset only program counter undefined
// R12: Status word 02H after reset
// R13: Port latch 00, direction FF, pull-up 00
// R14: Request flags 00, masks FF, edge mode 00
// R15: Timer counter, compares 0000, controls 00
// R16: Flash status, command, compares, buffer 00
// R17: Memory contents kept during standby
// R18: Board holds reset pin low 2 us
// R19: Internal resets release automatically, then start
// R20: Merge sources, sync release, capture cause
`timescale 1ns/100ps
`include "rsc_map.vh"
module rsc_reset_ctrl #(
  parameter CNT_W         = 21,
  parameter HOLD_INT_CYC  = `RSC_STOP_INT_TYP_CYC,
  parameter HOLD_XTAL_CYC = `RSC_STOP_XTAL_TYP_CYC,
  parameter OSTAB_CYC     = `RSC_OSTAB_CYC
) (
  mclk,
  rst_n,
  ext_reset_pin_n,
  watchdog_overflow,
  power_on_clear,
  undervoltage_below,
  osc_crystal,
  standby,
  bus_addr,
  bus_rd,
  bus_wr,
  bus_wdata,
  bus_rdata_r,
  mem_rdata,
  mem_rd_r,
  mem_addr_r,
  pc_r,
  pc_valid_r,
  cpu_hold_r,
  sys_reset_r,
  watchdog_reset_r,
  hw_init_r,
  ram_write_en_r,
  uv_enable_r,
  uv_reset_mode_r,
  uv_level_r,
  rv_psw_r,
  rv_port_latch_r,
  rv_port_dir_r,
  rv_pullup_r,
  rv_irq_flag_r,
  rv_irq_mask_r,
  rv_edge_mode_r,
  rv_tm_count_r,
  rv_tm_cc_r,
  rv_tm_ctrl_r,
  rv_flash_r
);
  input  wire        mclk;
  input  wire        rst_n;
  input  wire        ext_reset_pin_n;
  input  wire        watchdog_overflow;
  input  wire        power_on_clear;
  input  wire        undervoltage_below;
  input  wire        osc_crystal;
  input  wire        standby;
  input  wire [15:0] bus_addr;
  input  wire        bus_rd;
  input  wire        bus_wr;
  input  wire [7:0]  bus_wdata;
  output reg  [7:0]  bus_rdata_r;
  input  wire [7:0]  mem_rdata;
  output reg         mem_rd_r;
  output reg  [15:0] mem_addr_r;
  output reg  [15:0] pc_r;
  output reg         pc_valid_r;
  output reg         cpu_hold_r;
  output reg         sys_reset_r;
  output reg         watchdog_reset_r;
  output reg         hw_init_r;
  output reg         ram_write_en_r;
  output reg         uv_enable_r;
  output reg         uv_reset_mode_r;
  output reg  [3:0]  uv_level_r;
  output reg  [7:0]  rv_psw_r;
  output reg  [7:0]  rv_port_latch_r;
  output reg  [7:0]  rv_port_dir_r;
  output reg  [7:0]  rv_pullup_r;
  output reg  [7:0]  rv_irq_flag_r;
  output reg  [7:0]  rv_irq_mask_r;
  output reg  [7:0]  rv_edge_mode_r;
  output reg  [15:0] rv_tm_count_r;
  output reg  [15:0] rv_tm_cc_r;
  output reg  [7:0]  rv_tm_ctrl_r;
  output reg  [7:0]  rv_flash_r;

  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_HOLD  = 3'h1;
  localparam [2:0] ST_OSTAB = 3'h2;
  localparam [2:0] ST_VEC0  = 3'h3;
  localparam [2:0] ST_VEC1  = 3'h4;
  localparam [2:0] ST_LOAD  = 3'h5;
  localparam [2:0] ST_RUN   = 3'h6;

  localparam [31:0] HOLD_INT_END  = HOLD_INT_CYC - 1;
  localparam [31:0] HOLD_XTAL_END = HOLD_XTAL_CYC - 1;
  localparam [31:0] OSTAB_END     = OSTAB_CYC - 1;

  reg  [2:0]       state_r;
  reg  [2:0]       state_nxt;
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  reg              req_d_r;
  reg              cause_wdt_r;
  reg              cause_uv_r;
  reg  [7:0]       pc_lo_r;
  reg  [7:0]       rdata_nxt;

  wire             uv_reset_req;
  wire             src_req;
  wire             req_rise;
  wire             clr_src;
  wire             rst_sync_n;
  wire             cause_rd;
  wire             bus_ok;

  // Register address match
  function hit;
    input [15:0] a;
    input [15:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // R20: merged reset request
  assign uv_reset_req = undervoltage_below & uv_enable_r & uv_reset_mode_r;
  assign src_req      = ~ext_reset_pin_n | watchdog_overflow |
                        power_on_clear | uv_reset_req;
  assign req_rise     = src_req & ~req_d_r;
  assign clr_src      = ~ext_reset_pin_n | power_on_clear;
  assign bus_ok       = (state_r == ST_RUN);
  assign cause_rd     = bus_ok & bus_rd & hit(bus_addr, `RSC_ADDR_CAUSE);

  // R20: release synchronised to mclk
  rsc_rst_sync i_rsc_rst_sync (
    .mclk       (mclk),
    .arst_n     (rst_n & ~src_req),
    .rst_sync_n (rst_sync_n)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= src_req;
    end
  end

  // Cause flag capture
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cause_wdt_r <= 1'b0;
      cause_uv_r  <= 1'b0;
    end else if (req_rise & clr_src) begin
      // R3: pin or power-on clears all
      cause_wdt_r <= 1'b0;
      cause_uv_r  <= 1'b0;
    end else begin
      // R4: watchdog sets, read clears, set wins
      cause_wdt_r <= (req_rise & watchdog_overflow) |
                     (cause_wdt_r & ~cause_rd);
      // R5: undervoltage sets, read clears, set wins
      cause_uv_r  <= (req_rise & uv_reset_req) |
                     (cause_uv_r & ~cause_rd);
    end
  end

  // Undervoltage control and level registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uv_enable_r     <= 1'b0;
      uv_reset_mode_r <= 1'b0;
      uv_level_r      <= 4'h0;
    end else if (src_req & (clr_src | watchdog_overflow)) begin
      // R6: cleared unless undervoltage is the sole cause
      uv_enable_r     <= 1'b0;
      uv_reset_mode_r <= 1'b0;
      uv_level_r      <= 4'h0;
    end else if (bus_ok & bus_wr) begin
      if (hit(bus_addr, `RSC_ADDR_LVCTL)) begin
        uv_enable_r     <= bus_wdata[`RSC_LVCTL_EN_BIT];
        uv_reset_mode_r <= bus_wdata[`RSC_LVCTL_MODE_BIT];
      end
      if (hit(bus_addr, `RSC_ADDR_LVLVL)) begin
        uv_level_r <= bus_wdata[3:0];
      end
    end
  end

  // Read data mux
  always @* begin
    rdata_nxt = 8'h00;
    if (bus_ok & bus_rd) begin
      if (hit(bus_addr, `RSC_ADDR_CAUSE)) begin
        // R1: only bits 4 and 0 carry flags
        rdata_nxt[`RSC_CAUSE_WDT_BIT] = cause_wdt_r;
        rdata_nxt[`RSC_CAUSE_UV_BIT]  = cause_uv_r;
      end else if (hit(bus_addr, `RSC_ADDR_LVCTL)) begin
        rdata_nxt[`RSC_LVCTL_EN_BIT]   = uv_enable_r;
        rdata_nxt[`RSC_LVCTL_MODE_BIT] = uv_reset_mode_r;
        rdata_nxt[`RSC_LVCTL_FLAG_BIT] = undervoltage_below & uv_enable_r;
      end else if (hit(bus_addr, `RSC_ADDR_LVLVL)) begin
        rdata_nxt = {4'h0, uv_level_r};
      end
    end
  end

  // R2: byte read port; writes to cause ignored
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_r <= 8'h00;
    end else begin
      bus_rdata_r <= rdata_nxt;
    end
  end

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 1'b1;
    case (state_r)
      ST_RESET: begin
        cnt_nxt = {CNT_W{1'b0}};
        // R19: internal sources release on their own
        if (rst_sync_n) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // R8: hold for configuration fetch, internal clock
        // R9: hold for configuration fetch, crystal
        if ((!osc_crystal && cnt_r == HOLD_INT_END[CNT_W-1:0]) ||
            (osc_crystal && cnt_r == HOLD_XTAL_END[CNT_W-1:0])) begin
          cnt_nxt   = {CNT_W{1'b0}};
          state_nxt = osc_crystal ? ST_OSTAB : ST_VEC0;
        end
      end
      ST_OSTAB: begin
        if (cnt_r == OSTAB_END[CNT_W-1:0]) begin
          cnt_nxt   = {CNT_W{1'b0}};
          state_nxt = ST_VEC0;
        end
      end
      ST_VEC0: begin
        state_nxt = ST_VEC1;
      end
      ST_VEC1: begin
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        cnt_nxt = {CNT_W{1'b0}};
      end
      default: begin
        state_nxt = ST_RESET;
        cnt_nxt   = {CNT_W{1'b0}};
      end
    endcase
    if (!rst_sync_n) begin
      state_nxt = ST_RESET;
      cnt_nxt   = {CNT_W{1'b0}};
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
      cnt_r   <= {CNT_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Control outputs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_hold_r       <= 1'b1;
      sys_reset_r      <= 1'b1;
      watchdog_reset_r <= 1'b0;
      hw_init_r        <= 1'b0;
      ram_write_en_r   <= 1'b0;
      mem_rd_r         <= 1'b0;
      mem_addr_r       <= `RSC_VEC_LO_ADDR;
    end else begin
      cpu_hold_r       <= (state_nxt != ST_RUN);
      sys_reset_r      <= (state_nxt == ST_RESET);
      // R7: watchdog reset also clears the watchdog
      watchdog_reset_r <= src_req & watchdog_overflow;
      // R11: hardware initialised one cycle after ST_VEC0, during the second vector read
      hw_init_r        <= (state_r == ST_VEC0) & rst_sync_n;
      // R17: memory frozen in standby and during reset
      ram_write_en_r   <= (state_nxt == ST_RUN) & ~standby;
      mem_rd_r         <= (state_nxt == ST_VEC0) |
                          (state_nxt == ST_VEC1);
      mem_addr_r       <= (state_nxt == ST_VEC1) ? `RSC_VEC_HI_ADDR :
                                                   `RSC_VEC_LO_ADDR;
    end
  end

  // R10: program counter from reset vector
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_lo_r    <= 8'h00;
      pc_r       <= 16'h0000;
      pc_valid_r <= 1'b0;
    end else begin
      if (state_r == ST_VEC1) begin
        pc_lo_r <= mem_rdata;
      end
      if (state_r == ST_LOAD && rst_sync_n) begin
        pc_r       <= {mem_rdata, pc_lo_r};
        pc_valid_r <= 1'b1;
      end else if (!rst_sync_n) begin
        // R11: only the program counter is undefined
        pc_valid_r <= 1'b0;
      end
    end
  end

  // Reset values handed to the peripherals with hw_init_r
  always @(posedge mclk) begin
    // R12: status word value
    rv_psw_r        <= `RSC_RV_PSW;
    // R13: port latch, direction, pull-up
    rv_port_latch_r <= `RSC_RV_PORT_LATCH;
    rv_port_dir_r   <= `RSC_RV_PORT_DIR;
    rv_pullup_r     <= `RSC_RV_PULLUP;
    // R14: interrupt flags, masks, edge mode
    rv_irq_flag_r   <= `RSC_RV_IRQ_FLAG;
    rv_irq_mask_r   <= `RSC_RV_IRQ_MASK;
    rv_edge_mode_r  <= `RSC_RV_EDGE_MODE;
    // R15: timer counter, compares, controls
    rv_tm_count_r   <= `RSC_RV_TM_COUNT;
    rv_tm_cc_r      <= `RSC_RV_TM_CC;
    rv_tm_ctrl_r    <= `RSC_RV_TM_CTRL;
    // R16: flash status, command, compares, buffer
    rv_flash_r      <= `RSC_RV_FLASH;
  end
endmodule

// file: testbench/rsc_reset_ctrl_asserts.sv
// Port checker for the reset controller
`timescale 1ns/100ps
module rsc_reset_ctrl_asserts #(
  parameter HOLD_INT_CYC  = 20,
  parameter HOLD_XTAL_CYC = 30,
  parameter OSTAB_CYC     = 16
) (
  input logic        mclk,
  input logic        rst_n,
  input logic        ext_reset_pin_n,
  input logic        watchdog_overflow,
  input logic        power_on_clear,
  input logic        osc_crystal,
  input logic        standby,
  input logic [15:0] bus_addr,
  input logic        bus_rd,
  input logic [7:0]  bus_rdata_r,
  input logic [7:0]  mem_rdata,
  input logic        mem_rd_r,
  input logic [15:0] mem_addr_r,
  input logic [15:0] pc_r,
  input logic        pc_valid_r,
  input logic        cpu_hold_r,
  input logic        sys_reset_r,
  input logic        watchdog_reset_r,
  input logic        hw_init_r,
  input logic        ram_write_en_r,
  input logic        uv_enable_r,
  input logic [3:0]  uv_level_r,
  input logic [7:0]  rv_psw_r,
  input logic [7:0]  rv_port_dir_r,
  input logic [7:0]  rv_irq_mask_r,
  input logic [15:0] rv_tm_count_r,
  input logic [7:0]  rv_flash_r
);
  logic [20:0] hold_cnt;

  // Cycles the CPU stays held after the merged reset drops
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) hold_cnt <= 21'h0;
    else if (sys_reset_r) hold_cnt <= 21'h0;
    else if (cpu_hold_r) hold_cnt <= hold_cnt + 21'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_vec0; mem_rd_r && mem_addr_r == 16'h0000; endsequence
  sequence s_vec1; mem_rd_r && mem_addr_r == 16'h0001 && hw_init_r; endsequence
  sequence s_load; !mem_rd_r ##1 pc_valid_r && !cpu_hold_r; endsequence

  property p_cause;
    bus_rd && bus_addr == 16'hff54 && !cpu_hold_r
      |=> (bus_rdata_r & 8'hee) == 8'h00;
  endproperty
  property p_wdt; watchdog_overflow |-> ##[0:2] watchdog_reset_r; endproperty
  property p_hold_int;
    $fell(cpu_hold_r) && !osc_crystal |-> hold_cnt >= HOLD_INT_CYC;
  endproperty
  property p_hold_xtal;
    $fell(cpu_hold_r) && osc_crystal
      |-> hold_cnt >= HOLD_XTAL_CYC + OSTAB_CYC;
  endproperty
  property p_vec; $rose(mem_rd_r) |-> s_vec0 ##1 s_vec1 ##1 s_load; endproperty
  property p_pc;
    $rose(pc_valid_r) |-> pc_r == {$past(mem_rdata), $past(mem_rdata, 2)};
  endproperty
  property p_uv_clr;
    watchdog_overflow || power_on_clear || !ext_reset_pin_n
      |=> !uv_enable_r && uv_level_r == 4'h0;
  endproperty
  property p_standby; standby && $past(standby) |-> !ram_write_en_r; endproperty
  property p_psw; rv_psw_r == 8'h02; endproperty
  property p_dir; rv_port_dir_r == 8'hff; endproperty
  property p_mask; rv_irq_mask_r == 8'hff; endproperty
  property p_tmr; rv_tm_count_r == 16'h0000; endproperty
  property p_flash; rv_flash_r == 8'h00; endproperty

  a_cause: assert property (p_cause)
    else $error("cause bits");
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset");
  a_hold_int: assert property (p_hold_int)
    else $error("short hold");
  a_hold_xtal: assert property (p_hold_xtal)
    else $error("short crystal hold");
  a_vec: assert property (p_vec)
    else $error("vector fetch");
  a_pc: assert property (p_pc)
    else $error("pc load");
  a_uv_clr: assert property (p_uv_clr)
    else $error("uv regs kept");
  a_standby: assert property (p_standby)
    else $error("ram write in standby");
  a_psw: assert property (p_psw)
    else $error("psw");
  a_dir: assert property (p_dir)
    else $error("port dir");
  a_mask: assert property (p_mask)
    else $error("irq mask");
  a_tmr: assert property (p_tmr)
    else $error("timer");
  a_flash: assert property (p_flash)
    else $error("flash");
endmodule

// file: testbench/rsc_board_model.sv
// Board logic driving the external reset pin
`timescale 1ns/100ps
module rsc_board_model #(
  parameter LOW_CYC = 80
) (
  input  wire mclk,
  input  wire req,
  output reg  pin_n
);
  integer cnt;

  initial pin_n = 1'b1;
  initial cnt = 0;

  always @(posedge mclk) begin
    if (req) cnt <= LOW_CYC;
    else if (cnt > 0) cnt <= cnt - 1;
    pin_n <= !(req || cnt > 1);
  end
endmodule

// file: testbench/rsc_reset_ctrl_test.sv
// Self-checking bench for the reset controller
`timescale 1ns/100ps
`include "rsc_map.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module rsc_reset_ctrl_test;
  reg         mclk, rst_n, pin_req, watchdog_overflow, power_on_clear;
  reg         undervoltage_below, osc_crystal, standby, bus_rd, bus_wr;
  reg  [15:0] bus_addr;
  reg  [7:0]  bus_wdata, mem_rdata;
  wire        ext_reset_pin_n, mem_rd_r, pc_valid_r, cpu_hold_r;
  wire        sys_reset_r, watchdog_reset_r, hw_init_r, ram_write_en_r;
  wire        uv_enable_r, uv_reset_mode_r;
  wire [3:0]  uv_level_r;
  wire [7:0]  bus_rdata_r, rv_psw_r, rv_port_latch_r, rv_port_dir_r;
  wire [7:0]  rv_pullup_r, rv_irq_flag_r, rv_irq_mask_r, rv_edge_mode_r;
  wire [7:0]  rv_tm_ctrl_r, rv_flash_r;
  wire [15:0] mem_addr_r, pc_r, rv_tm_count_r, rv_tm_cc_r;
  integer     err_count, check_count, n;

  rsc_reset_ctrl #(
    .HOLD_INT_CYC  (20),
    .HOLD_XTAL_CYC (30),
    .OSTAB_CYC     (16)
  ) i_rsc_reset_ctrl (
    .mclk, .rst_n, .ext_reset_pin_n, .watchdog_overflow, .power_on_clear,
    .undervoltage_below, .osc_crystal, .standby, .bus_addr, .bus_rd,
    .bus_wr, .bus_wdata, .bus_rdata_r, .mem_rdata, .mem_rd_r, .mem_addr_r,
    .pc_r, .pc_valid_r, .cpu_hold_r, .sys_reset_r, .watchdog_reset_r,
    .hw_init_r, .ram_write_en_r, .uv_enable_r, .uv_reset_mode_r,
    .uv_level_r, .rv_psw_r, .rv_port_latch_r, .rv_port_dir_r, .rv_pullup_r,
    .rv_irq_flag_r, .rv_irq_mask_r, .rv_edge_mode_r, .rv_tm_count_r,
    .rv_tm_cc_r, .rv_tm_ctrl_r, .rv_flash_r
  );

  rsc_board_model #(.LOW_CYC(80)) i_rsc_board_model (
    .mclk(mclk), .req(pin_req), .pin_n(ext_reset_pin_n)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) mem_rdata <= mem_addr_r[0] ? 8'h12 : 8'h34;

  task results;
    begin
      if (err_count == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task run_wait;
    begin
      n = 0;
      while (cpu_hold_r !== 1'b0 && n < 4000) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      `CHK("cpu_hold_r", 1'b0, cpu_hold_r)
    end
  endtask

  task src(input integer k);
    begin
      @(posedge mclk);
      watchdog_overflow <= (k == 0);
      power_on_clear <= (k == 1);
      undervoltage_below <= (k == 2);
      pin_req <= (k == 3);
      repeat (4) @(posedge mclk);
      #1;
      if (k == 0) `CHK("watchdog_reset_r", 1'b1, watchdog_reset_r)
      @(posedge mclk);
      watchdog_overflow <= 1'b0;
      power_on_clear <= 1'b0;
      undervoltage_below <= 1'b0;
      pin_req <= 1'b0;
      run_wait;
    end
  endtask

  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
    end
  endtask

  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1;
      `CHK("bus_rdata_r", e, bus_rdata_r)
    end
  endtask

  initial begin
    err_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    pin_req = 1'b0;
    watchdog_overflow = 1'b0;
    power_on_clear = 1'b0;
    undervoltage_below = 1'b0;
    osc_crystal = 1'b0;
    standby = 1'b0;
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    run_wait;
    `CHK("pc_r", 16'h1234, pc_r)
    `CHK("rv_psw_r", 8'h02, rv_psw_r)
    `CHK("rv_port_latch_r", 8'h00, rv_port_latch_r)
    `CHK("rv_pullup_r", 8'h00, rv_pullup_r)
    `CHK("rv_irq_flag_r", 8'h00, rv_irq_flag_r)
    `CHK("rv_edge_mode_r", 8'h00, rv_edge_mode_r)
    `CHK("rv_tm_cc_r", 16'h0000, rv_tm_cc_r)
    `CHK("rv_tm_ctrl_r", 8'h00, rv_tm_ctrl_r)
    `CHK("sys_reset_r", 1'b0, sys_reset_r)
    rd(`RSC_ADDR_CAUSE, 8'h00);
    rd(16'hff00, 8'h00);
    src(0);
    rd(`RSC_ADDR_CAUSE, 8'h10);
    rd(`RSC_ADDR_CAUSE, 8'h00);
    src(0);
    wr(`RSC_ADDR_CAUSE, 8'hff);
    wr(`RSC_ADDR_LVCTL, 8'h82);
    wr(`RSC_ADDR_LVLVL, 8'h05);
    src(2);
    rd(`RSC_ADDR_LVCTL, 8'h82);
    rd(`RSC_ADDR_LVLVL, 8'h05);
    `CHK("uv_reset_mode_r", 1'b1, uv_reset_mode_r)
    rd(`RSC_ADDR_CAUSE, 8'h11);
    wr(`RSC_ADDR_LVCTL, 8'h82);
    src(2);
    src(0);
    rd(`RSC_ADDR_LVLVL, 8'h00);
    rd(`RSC_ADDR_CAUSE, 8'h11);
    src(0);
    @(posedge mclk);
    osc_crystal <= 1'b1;
    src(3);
    rd(`RSC_ADDR_CAUSE, 8'h00);
    @(posedge mclk);
    osc_crystal <= 1'b0;
    src(0);
    src(1);
    rd(`RSC_ADDR_CAUSE, 8'h00);
    @(posedge mclk);
    standby <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("ram_write_en_r", 1'b0, ram_write_en_r)
    @(posedge mclk);
    standby <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("ram_write_en_r", 1'b1, ram_write_en_r)
    results;
  end

  initial begin
    repeat (30000) @(posedge mclk);
    err_count = err_count + 1;
    results;
  end
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_asserts #(
  .HOLD_INT_CYC(HOLD_INT_CYC), .HOLD_XTAL_CYC(HOLD_XTAL_CYC),
  .OSTAB_CYC(OSTAB_CYC)
) i_rsc_reset_ctrl_asserts (
  .mclk, .rst_n, .ext_reset_pin_n, .watchdog_overflow, .power_on_clear,
  .osc_crystal, .standby, .bus_addr, .bus_rd, .bus_rdata_r, .mem_rdata,
  .mem_rd_r, .mem_addr_r, .pc_r, .pc_valid_r, .cpu_hold_r, .sys_reset_r,
  .watchdog_reset_r, .hw_init_r, .ram_write_en_r, .uv_enable_r,
  .uv_level_r, .rv_psw_r, .rv_port_dir_r, .rv_irq_mask_r, .rv_tm_count_r,
  .rv_flash_r
);
